/* File: rtl/hpd_qualifier.sv */
// Hot-plug qualifier: valid only after a long continuous high level
`timescale 1ns/1ps
module hpd_qualifier #(
  parameter int HOLD_CYC = sideband_pkg::HPD_HOLD_CYC
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Hot-plug level and qualified result
  input  wire logic hpd_level,
  output logic      hpd_valid
);
  import sideband_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic        valid;
  } hpd_t;

  hpd_t s_r;
  hpd_t s_nxt;

  // Count high time, drop at once on low
  always_comb begin
    s_nxt = s_r;
    if (!hpd_level) begin
      s_nxt.cnt   = 32'h0;
      s_nxt.valid = 1'b0;
    end else if (s_r.cnt > 32'(HOLD_CYC)) begin
      s_nxt.valid = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 32'h1;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hpd_valid = s_r.valid;

endmodule

/* File: rtl/sideband_pkg.sv */
// Shared constants for the hot-plug, oversampling and display-data sideband logic
package sideband_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ          = 200_000_000;
  localparam int          HPD_HOLD_MS     = 100;
  localparam int          HPD_HOLD_CYC    = (CLK_HZ / 1000) * HPD_HOLD_MS;
  localparam int          I2C_RATE_HZ     = 100_000;
  localparam logic [15:0] PRESCALE_RST    = 16'((CLK_HZ / (I2C_RATE_HZ * 4)) - 1);

  // ----------------------------------------------------------------
  // Port widths
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 32;
  localparam int          RATE_W          = 16;

  // ----------------------------------------------------------------
  // Memory-mapped map of the display-data master (word addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_PRESCALE    = 4'h0;
  localparam logic [3:0]  REG_COMMAND     = 4'h1;
  localparam logic [3:0]  REG_STATUS      = 4'h2;

  // Command fields
  localparam int          CMD_DATA_LSB    = 0;
  localparam int          CMD_START_BIT   = 8;
  localparam int          CMD_STOP_BIT    = 9;
  localparam int          CMD_WRITE_BIT   = 10;
  localparam int          CMD_READ_BIT    = 11;
  localparam int          CMD_NACK_BIT    = 12;

  // Status fields
  localparam int          STS_BUSY_BIT    = 0;
  localparam int          STS_ACKERR_BIT  = 1;
  localparam int          STS_RX_LSB      = 8;

  // ----------------------------------------------------------------
  // Oversampling select codes and line-rate band edges in Mb/s
  // ----------------------------------------------------------------
  localparam logic [1:0]  OVS_NONE        = 2'h0;
  localparam logic [1:0]  OVS_3X          = 2'h1;
  localparam logic [1:0]  OVS_4X          = 2'h2;
  localparam logic [1:0]  OVS_5X          = 2'h3;
  localparam logic [15:0] RATE_1G         = 16'h03e8;
  localparam logic [15:0] RATE_500M       = 16'h01f4;
  localparam logic [15:0] RATE_350M       = 16'h015e;
  localparam logic [15:0] RATE_300M       = 16'h012c;

  // ----------------------------------------------------------------
  // Display-data master states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_DATA  = 3'b010,
    ST_ACK   = 3'b011,
    ST_STOP  = 3'b100
  } i2c_state_t;

endpackage

/* File: rtl/source_hpd_and_sideband_ports.sv */
// Sideband ports: hot-plug qualifier, oversampling select, display-data master
`timescale 1ns/1ps
// How it works
// - Hot-plug valid rises only after input stays high over 100 ms.
// - Hot-plug valid drops as soon as the input goes low.
// - Master drives two-way clock and data lines of the display-data bus.
// - Memory-mapped port: 4-bit address, read/write strobes, 32-bit data.
// - With the master option off, bus lines and port do nothing.
module source_hpd_and_sideband_ports #(
  parameter int HOLD_CYC    = sideband_pkg::HPD_HOLD_CYC,
  parameter bit INCLUDE_I2C = 1'b1
) (
  // Clock and reset
  input  wire logic                            mclk,
  input  wire logic                            rst,
  // Hot-plug
  input  wire logic                            hpd_in,
  output logic                                 hpd_valid,
  // Oversampling helper
  input  wire logic [sideband_pkg::RATE_W-1:0] line_rate_mbps,
  output logic [1:0]                           oversample_factor_sel,
  // Display-data clock line
  input  wire logic                            scl_in,
  output logic                                 scl_out,
  output logic                                 scl_oe_n,
  // Display-data data line
  input  wire logic                            sda_in,
  output logic                                 sda_out,
  output logic                                 sda_oe_n,
  // Memory-mapped port of the master
  input  wire logic [sideband_pkg::ADDR_W-1:0] i2c_address,
  input  wire logic                            i2c_write,
  input  wire logic                            i2c_read,
  input  wire logic [sideband_pkg::DATA_W-1:0] i2c_writedata,
  output logic [sideband_pkg::DATA_W-1:0]      i2c_readdata
);
  import sideband_pkg::*;

  // ----------------------------------------------------------------
  // State of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    i2c_state_t  st;
    logic [1:0]  q;
    logic [2:0]  bitn;
    logic [7:0]  sh;
    logic        wr;
    logic        rd;
    logic        stp;
    logic        nack;
    logic        ack_err;
    logic [7:0]  rx;
    logic [15:0] pre;
    logic [15:0] div;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic [31:0] rdata;
    logic [1:0]  ovs;
  } main_t;

  main_t s_r;
  main_t s_nxt;
  logic  hpd_ok;

  // ----------------------------------------------------------------
  // Hot-plug qualifier
  // ----------------------------------------------------------------
  // The connector level is fed straight in, no extra filtering
  hpd_qualifier #(
    .HOLD_CYC (HOLD_CYC)
  ) u_hpd (
    .mclk      (mclk),
    .rst       (rst),
    .hpd_level (hpd_in),
    .hpd_valid (hpd_ok)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic tick;
    logic stall;
    logic bus_busy;
    tick     = 1'b0;
    stall    = 1'b0;
    bus_busy = 1'b0;
    s_nxt    = s_r;

    // Oversampling select from line rate
    if (line_rate_mbps >= RATE_1G) begin
      s_nxt.ovs = OVS_NONE;
    end else if (line_rate_mbps >= RATE_500M) begin
      s_nxt.ovs = OVS_5X;
    end else if (line_rate_mbps >= RATE_350M) begin
      s_nxt.ovs = OVS_3X;
    end else if (line_rate_mbps >= RATE_300M) begin
      s_nxt.ovs = OVS_4X;
    end else begin
      s_nxt.ovs = OVS_5X;
    end

    // Quarter-bit enable divider
    if (s_r.div == 16'h0) begin
      s_nxt.div = s_r.pre;
      tick      = 1'b1;
    end else begin
      s_nxt.div = s_r.div - 16'h1;
    end

    // Clock stretching: hold the high phase until the line is high
    stall    = (s_r.q == 2'd2) && !scl_in;
    bus_busy = (s_r.st != ST_IDLE);

    // Register port: reads answer one cycle later
    if (i2c_read && INCLUDE_I2C) begin
      unique case (i2c_address)
        REG_PRESCALE: s_nxt.rdata = {16'h0, s_r.pre};
        REG_STATUS:   s_nxt.rdata = {16'h0, s_r.rx, 6'h0, s_r.ack_err, bus_busy};
        default:      s_nxt.rdata = 32'h0;
      endcase
    end

    // Register writes; commands only taken while idle
    if (i2c_write && INCLUDE_I2C) begin
      unique case (i2c_address)
        REG_PRESCALE: s_nxt.pre = i2c_writedata[15:0];
        REG_STATUS: begin
          if (i2c_writedata[STS_ACKERR_BIT]) begin
            s_nxt.ack_err = 1'b0;
          end
        end
        REG_COMMAND: begin
          if (!bus_busy) begin
            s_nxt.sh   = i2c_writedata[CMD_DATA_LSB +: 8];
            s_nxt.wr   = i2c_writedata[CMD_WRITE_BIT];
            s_nxt.rd   = i2c_writedata[CMD_READ_BIT] & ~i2c_writedata[CMD_WRITE_BIT];
            s_nxt.stp  = i2c_writedata[CMD_STOP_BIT];
            s_nxt.nack = i2c_writedata[CMD_NACK_BIT];
            s_nxt.q    = 2'd0;
            s_nxt.bitn = 3'd7;
            if (i2c_writedata[CMD_START_BIT]) begin
              s_nxt.st = ST_START;
            end else if (i2c_writedata[CMD_WRITE_BIT] | i2c_writedata[CMD_READ_BIT]) begin
              s_nxt.st = ST_DATA;
            end else if (i2c_writedata[CMD_STOP_BIT]) begin
              s_nxt.st = ST_STOP;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Bit engine, one phase per quarter-bit tick
    if (tick && bus_busy && !stall) begin
      s_nxt.q = s_r.q + 2'd1;
      unique case (s_r.st)
        ST_START: begin
          unique case (s_r.q)
            2'd0: s_nxt.sda_oe_n = 1'b1;
            2'd1: s_nxt.scl_oe_n = 1'b1;
            2'd2: s_nxt.sda_oe_n = 1'b0;
            2'd3: begin
              s_nxt.scl_oe_n = 1'b0;
              if (s_r.wr | s_r.rd) begin
                s_nxt.st = ST_DATA;
              end else if (s_r.stp) begin
                s_nxt.st = ST_STOP;
              end else begin
                s_nxt.st = ST_IDLE;
              end
            end
          endcase
        end
        ST_DATA: begin
          unique case (s_r.q)
            2'd0: s_nxt.sda_oe_n = s_r.wr ? s_r.sh[7] : 1'b1;
            2'd1: s_nxt.scl_oe_n = 1'b1;
            2'd2: s_nxt.sh = {s_r.sh[6:0], sda_in};
            2'd3: begin
              s_nxt.scl_oe_n = 1'b0;
              s_nxt.bitn     = s_r.bitn - 3'd1;
              if (s_r.bitn == 3'd0) begin
                s_nxt.st = ST_ACK;
              end
            end
          endcase
        end
        ST_ACK: begin
          unique case (s_r.q)
            2'd0: s_nxt.sda_oe_n = s_r.wr ? 1'b1 : s_r.nack;
            2'd1: s_nxt.scl_oe_n = 1'b1;
            2'd2: begin
              if (s_r.wr && sda_in) begin
                s_nxt.ack_err = 1'b1;              // Set wins over clear
              end
              if (s_r.rd) begin
                s_nxt.rx = s_r.sh;
              end
            end
            2'd3: begin
              s_nxt.scl_oe_n = 1'b0;
              s_nxt.st       = s_r.stp ? ST_STOP : ST_IDLE;
            end
          endcase
        end
        ST_STOP: begin
          unique case (s_r.q)
            2'd0: s_nxt.sda_oe_n = 1'b0;
            2'd1: s_nxt.scl_oe_n = 1'b1;
            2'd2: s_nxt.sda_oe_n = 1'b1;
            2'd3: s_nxt.st = ST_IDLE;
          endcase
        end
        default: s_nxt.st = ST_IDLE;
      endcase
    end

    // Master left out: lines released, port reads zero
    if (!INCLUDE_I2C) begin
      s_nxt.st       = ST_IDLE;
      s_nxt.scl_oe_n = 1'b1;
      s_nxt.sda_oe_n = 1'b1;
      s_nxt.rdata    = 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r          <= '0;
      s_r.st       <= ST_IDLE;
      s_r.pre      <= PRESCALE_RST;
      s_r.scl_oe_n <= 1'b1;
      s_r.sda_oe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hpd_valid             = hpd_ok;
  assign oversample_factor_sel = s_r.ovs;
  assign scl_out               = 1'b0;             // Open drain: only ever pulls low
  assign sda_out               = 1'b0;
  assign scl_oe_n              = s_r.scl_oe_n;
  assign sda_oe_n              = s_r.sda_oe_n;
  assign i2c_readdata          = s_r.rdata;

endmodule

/* File: verification/ddc_sink_model.sv */
// Behavioural display sink answering on the display-data lines
`timescale 1ns/1ps
module ddc_sink_model #(
  parameter logic [6:0] DEV_ADDR = 7'h50,
  parameter logic [7:0] RD_BYTE  = 8'h5a
) (
  // Resolved wire levels
  input wire logic scl,
  input wire logic sda,
  // Pull-down on the data line
  output logic     sda_low
);
  int         cnt   = 0;
  logic       first = 1'b0;
  logic       rd    = 1'b0;
  logic [7:0] sh    = 8'h00;
  initial sda_low = 1'b0;
  // Start condition opens a frame
  always @(negedge sda) begin
    if (scl) begin
      cnt   = 0;
      first = 1'b1;
      rd    = 1'b0;
    end
  end
  // Shift in bits; a master NACK ends read data
  always @(posedge scl) begin
    if (cnt == 8 && rd && !first && sda) rd = 1'b0;
    if (cnt < 8) sh = {sh[6:0], sda};
    cnt = cnt + 1;
  end
  // Acknowledge or present read bits after clock fall
  always @(negedge scl) begin
    sda_low = 1'b0;
    if (cnt == 9) begin
      cnt = 0;
      if (first) rd = sh[0];
      first = 1'b0;
    end
    if (cnt == 8 && !(rd && !first)) sda_low = first ? (sh[7:1] == DEV_ADDR) : 1'b1;
    else if (cnt < 8 && rd && !first) sda_low = !RD_BYTE[7-cnt];
  end
endmodule

/* File: verification/sideband_assertions.sv */
// Checker of hot-plug, oversampling and register-port timing
`timescale 1ns/1ps
module sideband_assertions import sideband_pkg::*; #(
  parameter int HOLD_CYC = HPD_HOLD_CYC
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Watched ports
  input wire logic        hpd_in,
  input wire logic        hpd_valid,
  input wire logic [15:0] line_rate_mbps,
  input wire logic [1:0]  oversample_factor_sel,
  input wire logic        scl_oe_n,
  input wire logic        sda_oe_n,
  input wire logic [3:0]  i2c_address,
  input wire logic        i2c_write,
  input wire logic        i2c_read,
  input wire logic [31:0] i2c_writedata,
  input wire logic [31:0] i2c_readdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  int          run_r;
  logic [15:0] pre_r;
  // High-run length and last prescale written
  always_ff @(posedge mclk) begin
    run_r <= (rst || !hpd_in) ? 0 : run_r + 1;
    if (rst) pre_r <= PRESCALE_RST;
    else if (i2c_write && i2c_address == REG_PRESCALE) pre_r <= i2c_writedata[15:0];
  end
  // Expected code for a rate
  function automatic logic [1:0] band(input logic [15:0] r);
    if (r >= RATE_1G) return OVS_NONE;
    if (r >= RATE_500M) return OVS_5X;
    if (r >= RATE_350M) return OVS_3X;
    if (r >= RATE_300M) return OVS_4X;
    return OVS_5X;
  endfunction
  sequence s_cmd;
    i2c_write && i2c_address == REG_COMMAND && i2c_writedata[CMD_START_BIT];
  endsequence
  sequence s_poll;
    i2c_read && i2c_address == REG_STATUS;
  endsequence
  property p_valid_rise; $rose(hpd_valid) |-> run_r > HOLD_CYC + 1; endproperty
  property p_valid_fall; !hpd_in |=> !hpd_valid; endproperty
  property p_ovs; !$past(rst) |=> oversample_factor_sel == band($past(line_rate_mbps)); endproperty
  property p_idle; $fell(rst) |-> scl_oe_n && sda_oe_n && !hpd_valid && i2c_readdata == 0; endproperty
  property p_busy; s_cmd ##1 s_poll |=> i2c_readdata[STS_BUSY_BIT]; endproperty
  property p_unmapped; i2c_read && i2c_address > REG_STATUS |=> i2c_readdata == 0; endproperty
  property p_pre; i2c_read && i2c_address == REG_PRESCALE |=> i2c_readdata == {16'h0000, pre_r}; endproperty
  property p_hold; !i2c_read |=> $stable(i2c_readdata); endproperty
  a_valid_rise: assert property (p_valid_rise) else $error("hot-plug valid too early");
  a_valid_fall: assert property (p_valid_fall) else $error("hot-plug valid kept");
  a_ovs: assert property (p_ovs) else $error("wrong oversampling code");
  a_idle: assert property (p_idle) else $error("outputs not idle after reset");
  a_busy: assert property (p_busy) else $error("busy not seen after command");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_pre: assert property (p_pre) else $error("prescale readback wrong");
  a_hold: assert property (p_hold) else $error("read data moved without read");
endmodule

/* File: verification/tb_top.sv */
// Testbench of the sideband ports with a display sink on the data lines
`timescale 1ns/1ps
module tb_top;
  import sideband_pkg::*;
  localparam int HOLD = 20;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        hpd_in = 1'b0; // Same net as the connector pin
  logic        hpd_valid;
  logic [15:0] line_rate_mbps = 16'h0000;
  logic [1:0]  oversample_factor_sel;
  logic        scl_out, scl_oe_n, sda_out, sda_oe_n, sink_low;
  logic [3:0]  i2c_address = 4'h0;
  logic        i2c_write = 1'b0;
  logic        i2c_read = 1'b0;
  logic [31:0] i2c_writedata = 32'h0;
  logic [31:0] i2c_readdata, rdv;
  int          fails = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // Open-drain lines with pull-ups
  wire scl = scl_oe_n ? 1'b1 : scl_out;
  wire sda = (sda_oe_n ? 1'b1 : sda_out) && !sink_low;
  source_hpd_and_sideband_ports #(.HOLD_CYC(HOLD)) u_source_hpd_and_sideband_ports (
    .mclk(mclk), .rst(rst), .hpd_in(hpd_in), .hpd_valid(hpd_valid),
    .line_rate_mbps(line_rate_mbps), .oversample_factor_sel(oversample_factor_sel),
    .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .i2c_address(i2c_address), .i2c_write(i2c_write), .i2c_read(i2c_read),
    .i2c_writedata(i2c_writedata), .i2c_readdata(i2c_readdata));
  ddc_sink_model u_ddc_sink_model (.scl(scl), .sda(sda), .sda_low(sink_low));
  initial forever #2.5 mclk = ~mclk;
  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  // Bus cycles, entered at a falling edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i2c_address = a;
    i2c_writedata = d;
    i2c_write = 1'b1;
    @(negedge mclk);
    i2c_write = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    i2c_address = a;
    i2c_read = 1'b1;
    @(negedge mclk);
    i2c_read = 1'b0;
    rdv = i2c_readdata;
    @(negedge mclk);
  endtask
  task automatic xfer(input logic [31:0] cmd);
    int n;
    n = 0;
    wr(REG_COMMAND, cmd);
    rd(REG_STATUS);
    check(rdv[STS_BUSY_BIT], 1'b1);
    while (rdv[STS_BUSY_BIT] !== 1'b0 && n < 400) begin
      rd(REG_STATUS);
      n++;
    end
    check(rdv[STS_BUSY_BIT], 1'b0);
  endtask
  task automatic t_reset();
    check({hpd_valid, scl_oe_n, sda_oe_n}, 3'b011);
    check({scl_out, sda_out}, 2'h0);
    rd(REG_PRESCALE);
    check(rdv, {16'h0000, PRESCALE_RST});
    rd(REG_STATUS);
    check(rdv, 32'h0);
  endtask
  task automatic t_ovs();
    logic [15:0] r [10] = '{16'h03e8, 16'h07d0, 16'h03e7, 16'h01f4, 16'h01f3,
                            16'h015e, 16'h015d, 16'h012c, 16'h012b, 16'h0064};
    logic [1:0]  e [10] = '{2'h0, 2'h0, 2'h3, 2'h3, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    for (int i = 0; i < 10; i++) begin
      line_rate_mbps = r[i];
      @(negedge mclk);
      check(oversample_factor_sel, e[i]);
    end
  endtask
  task automatic t_hpd();
    hpd_in = 1'b1;
    repeat (15) @(negedge mclk);
    hpd_in = 1'b0;
    @(negedge mclk);
    hpd_in = 1'b1;
    repeat (HOLD) @(negedge mclk);
    check(hpd_valid, 1'b0);
    repeat (4) @(negedge mclk);
    check(hpd_valid, 1'b1);
    hpd_in = 1'b0;
    @(negedge mclk);
    check(hpd_valid, 1'b0);
  endtask
  task automatic t_i2c();
    wr(REG_PRESCALE, 32'h1);
    rd(REG_PRESCALE);
    check(rdv, 32'h1);
    rd(4'h7);
    check(rdv, 32'h0);
    xfer(32'h5a0);
    xfer(32'h600);
    check(rdv[STS_ACKERR_BIT], 1'b0);
    xfer(32'h5a1);
    xfer(32'h1a00);
    check(rdv[15:8], 8'h5a);
    xfer(32'h742);
    check(rdv[STS_ACKERR_BIT], 1'b1);
    wr(REG_STATUS, 32'h2);
    rd(REG_STATUS);
    check({rdv[STS_ACKERR_BIT], scl_oe_n, sda_oe_n}, 3'b011);
  endtask
  initial begin
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_ovs();
    t_hpd();
    t_i2c();
    stop_test();
  end
endmodule
bind source_hpd_and_sideband_ports sideband_assertions #(.HOLD_CYC(HOLD_CYC)) u_sideband_assertions (
  .mclk(mclk), .rst(rst), .hpd_in(hpd_in), .hpd_valid(hpd_valid),
  .line_rate_mbps(line_rate_mbps), .oversample_factor_sel(oversample_factor_sel),
  .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .i2c_address(i2c_address),
  .i2c_write(i2c_write), .i2c_read(i2c_read), .i2c_writedata(i2c_writedata),
  .i2c_readdata(i2c_readdata));
